// [hw/mpq_pkg.sv]
// package: register map, reset values and carriers for the power quality register bank
package mpq_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int IDX_W   = 18;
  localparam int ADDR_W  = 20;
  localparam int DATA_W  = 32;
  localparam int PWR_W   = 24;
  localparam int HALF_W  = 16;
  localparam int PHASES  = 3;

  // ---------------------------------------------------------------
  // register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PHASE_A_APPARENT_POWER = 18'h0e519;
  localparam logic [IDX_W-1:0] IDX_PHASE_B_APPARENT_POWER = 18'h0e51a;
  localparam logic [IDX_W-1:0] IDX_PHASE_C_APPARENT_POWER = 18'h0e51b;
  localparam logic [IDX_W-1:0] IDX_CONFIG_CHECKSUM        = 18'h0e51f;
  localparam logic [IDX_W-1:0] IDX_NOMINAL_VOLTAGE        = 18'h0e520;
  localparam logic [IDX_W-1:0] IDX_RSVD0_LO               = 18'h0e521;
  localparam logic [IDX_W-1:0] IDX_RSVD0_HI               = 18'h0e52e;
  localparam logic [IDX_W-1:0] IDX_NOMINAL_VOLTAGE_ENABLE = 18'h0e530;
  localparam logic [IDX_W-1:0] IDX_PHASE_PEAK_STATUS      = 18'h0e600;
  localparam logic [IDX_W-1:0] IDX_PHASE_DELAY_0          = 18'h0e601;
  localparam logic [IDX_W-1:0] IDX_PHASE_DELAY_2          = 18'h0e603;
  localparam logic [IDX_W-1:0] IDX_RSVD1_LO               = 18'h0e604;
  localparam logic [IDX_W-1:0] IDX_RSVD1_HI               = 18'h0e606;
  localparam logic [IDX_W-1:0] IDX_LINE_PERIOD            = 18'h0e607;
  localparam logic [IDX_W-1:0] IDX_PHASE_NOLOAD_STATUS    = 18'h0e608;
  localparam logic [IDX_W-1:0] IDX_RSVD2_LO               = 18'h0e609;
  localparam logic [IDX_W-1:0] IDX_RSVD2_HI               = 18'h0e60b;
  localparam logic [IDX_W-1:0] IDX_LINE_CYCLE_COUNT       = 18'h0e60c;
  localparam logic [IDX_W-1:0] IDX_ZERO_CROSS_TIMEOUT     = 18'h0e60d;
  localparam logic [IDX_W-1:0] IDX_COMPUTATION_MODE       = 18'h0e60e;
  localparam logic [IDX_W-1:0] IDX_ADC_INPUT_GAIN         = 18'h0e60f;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_CONFIG_CHECKSUM    = 32'h33666787;
  localparam logic [PWR_W-1:0]  RST_NOMINAL_VOLTAGE    = 24'h000000;
  localparam logic [HALF_W-1:0] RST_LINE_CYCLE_COUNT   = 16'hffff;
  localparam logic [HALF_W-1:0] RST_ZERO_CROSS_TIMEOUT = 16'hffff;
  localparam logic [HALF_W-1:0] RST_COMPUTATION_MODE   = 16'h01ff;
  localparam logic [HALF_W-1:0] RST_ADC_INPUT_GAIN     = 16'h0000;
  localparam logic [PHASES-1:0] RST_NOM_ENABLE         = 3'h0;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PHASES-1:0][PWR_W-1:0]  apparent_power;
    logic [HALF_W-1:0]             phase_peak_status;
    logic [PHASES-1:0][HALF_W-1:0] phase_delay;
    logic [HALF_W-1:0]             line_period;
    logic [HALF_W-1:0]             phase_noload_status;
    logic                          checksum_upd;
    logic [DATA_W-1:0]             checksum;
  } mpq_dsp_t;

  typedef struct packed {
    logic [PWR_W-1:0]  nominal_voltage;
    logic [PHASES-1:0] nominal_voltage_enable;
    logic [HALF_W-1:0] line_cycle_count;
    logic [HALF_W-1:0] zero_cross_timeout;
    logic [HALF_W-1:0] computation_mode;
    logic [HALF_W-1:0] adc_input_gain;
  } mpq_cfg_t;

  typedef struct packed {
    logic                          pready;
    logic                          pslverr;
    logic [DATA_W-1:0]             prdata;
    logic [DATA_W-1:0]             checksum;
    mpq_cfg_t                      cfg;
    logic [PHASES-1:0][PWR_W-1:0]  vrms_used;
  } mpq_state_t;

endpackage

// [hw/mpq_regs.sv]
// module: APB register bank for apparent power, checksum and power quality registers
`timescale 1ns/1ps

// Notes on behaviour
// [RULE_01] apparent power readouts: 24-bit signed, read-only, read back sign-extended to 32.
// [RULE_02] checksum is read-only 32-bit and resets to its fixed value.
// [RULE_03] nominal voltage: writable 24-bit, resets to zero, read zero-padded to 32.
// [RULE_04] per-phase enable replaces measured rms voltage with nominal voltage value.
// [RULE_05] software never writes reserved ranges; such writes are dropped here.
// [RULE_06] phase peak status is read-only 16-bit, no reset value.
// [RULE_07] three read-only 16-bit phase delay registers follow the peak status.
// [RULE_08] phase no-load status is read-only 16-bit.
// [RULE_09] line cycle count is writable 16-bit, resets to all ones.
// [RULE_10] computation mode is writable 16-bit, resets to 0x01ff.
// [RULE_11] adc input gain is writable 16-bit, resets to zero.
// [RULE_12] writes to read-only registers change nothing and have no side effect.
module mpq_regs
(
  // clock and reset
  input  wire logic                                       sys_clk_i,
  input  wire logic                                       nrst_i,
  // apb slave
  input  wire logic                                       psel_i,
  input  wire logic                                       penable_i,
  input  wire logic                                       pwrite_i,
  input  wire logic [mpq_pkg::ADDR_W-1:0]                 paddr_i,
  input  wire logic [mpq_pkg::DATA_W-1:0]                 pwdata_i,
  input  wire logic [3:0]                                 pstrb_i,
  output logic      [mpq_pkg::DATA_W-1:0]                 prdata_o,
  output logic                                            pready_o,
  output logic                                            pslverr_o,
  // dsp readouts
  input  wire mpq_pkg::mpq_dsp_t                          dsp_i,
  input  wire logic [mpq_pkg::PHASES-1:0][mpq_pkg::PWR_W-1:0] meas_vrms_i,
  // configuration and substituted voltages
  output mpq_pkg::mpq_cfg_t                               cfg_o,
  output logic [mpq_pkg::PHASES-1:0][mpq_pkg::PWR_W-1:0]  vrms_used_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  mpq_pkg::mpq_state_t          st_r;
  mpq_pkg::mpq_state_t          st_nxt;
  logic [mpq_pkg::IDX_W-1:0]    idx;
  logic                         aligned;
  logic                         access;
  logic                         commit;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge32
  (
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] sext24(input logic [23:0] v);
    return {{8{v[23]}}, v};
  endfunction

  assign idx     = paddr_i[mpq_pkg::ADDR_W-1:2];
  assign aligned = (paddr_i[1:0] == 2'h0);
  // one wait state: data is decoded in the first access cycle, answered in the second
  assign access  = psel_i && penable_i && !st_r.pready;
  assign commit  = psel_i && penable_i && st_r.pready && pwrite_i && !st_r.pslverr;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [31:0] rd;
    logic        err;
    logic [31:0] m;
    rd     = 32'h0;
    err    = 1'b0;
    m      = 32'h0;
    st_nxt = st_r;

    st_nxt.pready  = access;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata  = 32'h0;

    // read decode and address check
    if (!aligned)
    begin
      err = 1'b1;
    end
    else if (idx == mpq_pkg::IDX_PHASE_A_APPARENT_POWER)
    begin
      rd = sext24(dsp_i.apparent_power[0]); // [RULE_01]
    end
    else if (idx == mpq_pkg::IDX_PHASE_B_APPARENT_POWER)
    begin
      rd = sext24(dsp_i.apparent_power[1]); // [RULE_01]
    end
    else if (idx == mpq_pkg::IDX_PHASE_C_APPARENT_POWER)
    begin
      rd = sext24(dsp_i.apparent_power[2]); // [RULE_01]
    end
    else if (idx == mpq_pkg::IDX_CONFIG_CHECKSUM)
    begin
      rd = st_r.checksum; // [RULE_02]
    end
    else if (idx == mpq_pkg::IDX_NOMINAL_VOLTAGE)
    begin
      rd = {8'h0, st_r.cfg.nominal_voltage}; // [RULE_03]
    end
    else if (idx == mpq_pkg::IDX_NOMINAL_VOLTAGE_ENABLE)
    begin
      rd = {29'h0, st_r.cfg.nominal_voltage_enable};
    end
    else if (idx == mpq_pkg::IDX_PHASE_PEAK_STATUS)
    begin
      rd = {16'h0, dsp_i.phase_peak_status}; // [RULE_06]
    end
    else if (idx >= mpq_pkg::IDX_PHASE_DELAY_0 && idx <= mpq_pkg::IDX_PHASE_DELAY_2)
    begin
      rd = {16'h0, dsp_i.phase_delay[idx[1:0] - 2'h1]}; // [RULE_07]
    end
    else if (idx == mpq_pkg::IDX_LINE_PERIOD)
    begin
      rd = {16'h0, dsp_i.line_period};
    end
    else if (idx == mpq_pkg::IDX_PHASE_NOLOAD_STATUS)
    begin
      rd = {16'h0, dsp_i.phase_noload_status}; // [RULE_08]
    end
    else if (idx == mpq_pkg::IDX_LINE_CYCLE_COUNT)
    begin
      rd = {16'h0, st_r.cfg.line_cycle_count}; // [RULE_09]
    end
    else if (idx == mpq_pkg::IDX_ZERO_CROSS_TIMEOUT)
    begin
      rd = {16'h0, st_r.cfg.zero_cross_timeout};
    end
    else if (idx == mpq_pkg::IDX_COMPUTATION_MODE)
    begin
      rd = {16'h0, st_r.cfg.computation_mode}; // [RULE_10]
    end
    else if (idx == mpq_pkg::IDX_ADC_INPUT_GAIN)
    begin
      rd = {16'h0, st_r.cfg.adc_input_gain}; // [RULE_11]
    end
    else
    begin
      // reserved ranges land here too: error, no write, read zero
      err = 1'b1; // [RULE_05]
    end

    if (access)
    begin
      st_nxt.pslverr = err;
      st_nxt.prdata  = (pwrite_i || err) ? 32'h0 : rd;
    end

    // checksum follows the dsp only when it publishes a new value
    if (dsp_i.checksum_upd)
    begin
      st_nxt.checksum = dsp_i.checksum; // [RULE_02]
    end

    // writes take effect at the completing edge only; read-only targets fall through
    if (commit)
    begin
      if (idx == mpq_pkg::IDX_NOMINAL_VOLTAGE)
      begin
        m = merge32({8'h0, st_r.cfg.nominal_voltage}, pwdata_i, pstrb_i);
        st_nxt.cfg.nominal_voltage = m[23:0]; // [RULE_03]
      end
      else if (idx == mpq_pkg::IDX_NOMINAL_VOLTAGE_ENABLE)
      begin
        m = merge32({29'h0, st_r.cfg.nominal_voltage_enable}, pwdata_i, pstrb_i);
        st_nxt.cfg.nominal_voltage_enable = m[2:0];
      end
      else if (idx == mpq_pkg::IDX_LINE_CYCLE_COUNT)
      begin
        m = merge32({16'h0, st_r.cfg.line_cycle_count}, pwdata_i, pstrb_i);
        st_nxt.cfg.line_cycle_count = m[15:0]; // [RULE_09]
      end
      else if (idx == mpq_pkg::IDX_ZERO_CROSS_TIMEOUT)
      begin
        m = merge32({16'h0, st_r.cfg.zero_cross_timeout}, pwdata_i, pstrb_i);
        st_nxt.cfg.zero_cross_timeout = m[15:0];
      end
      else if (idx == mpq_pkg::IDX_COMPUTATION_MODE)
      begin
        m = merge32({16'h0, st_r.cfg.computation_mode}, pwdata_i, pstrb_i);
        st_nxt.cfg.computation_mode = m[15:0]; // [RULE_10]
      end
      else if (idx == mpq_pkg::IDX_ADC_INPUT_GAIN)
      begin
        m = merge32({16'h0, st_r.cfg.adc_input_gain}, pwdata_i, pstrb_i);
        st_nxt.cfg.adc_input_gain = m[15:0]; // [RULE_11]
      end
      else
      begin
        // read-only target: contents stay, no side effect
        st_nxt.cfg = st_r.cfg; // [RULE_12]
      end
    end

    // substitution uses the stored nominal value, one cycle behind a write
    for (int p = 0; p < mpq_pkg::PHASES; p++)
    begin
      st_nxt.vrms_used[p] = st_r.cfg.nominal_voltage_enable[p] ?
                            st_r.cfg.nominal_voltage : meas_vrms_i[p]; // [RULE_04]
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      st_r.pready                     <= 1'b0;
      st_r.pslverr                    <= 1'b0;
      st_r.prdata                     <= 32'h0;
      st_r.checksum                   <= mpq_pkg::RST_CONFIG_CHECKSUM; // [RULE_02]
      st_r.cfg.nominal_voltage        <= mpq_pkg::RST_NOMINAL_VOLTAGE; // [RULE_03]
      st_r.cfg.nominal_voltage_enable <= mpq_pkg::RST_NOM_ENABLE;
      st_r.cfg.line_cycle_count       <= mpq_pkg::RST_LINE_CYCLE_COUNT; // [RULE_09]
      st_r.cfg.zero_cross_timeout     <= mpq_pkg::RST_ZERO_CROSS_TIMEOUT;
      st_r.cfg.computation_mode       <= mpq_pkg::RST_COMPUTATION_MODE; // [RULE_10]
      st_r.cfg.adc_input_gain         <= mpq_pkg::RST_ADC_INPUT_GAIN; // [RULE_11]
      st_r.vrms_used                  <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata_o    = st_r.prdata;
  assign pready_o    = st_r.pready;
  assign pslverr_o   = st_r.pslverr;
  assign cfg_o       = st_r.cfg;
  assign vrms_used_o = st_r.vrms_used;

endmodule

// [test/mpq_regs_chk.sv]
// checker: bus timing, readout format and voltage substitution of the register bank
`timescale 1ns/1ps
module mpq_regs_chk
(
  // clock and reset
  input wire logic                                            sys_clk_i,
  input wire logic                                            nrst_i,
  // apb
  input wire logic                                            psel_i,
  input wire logic                                            penable_i,
  input wire logic                                            pwrite_i,
  input wire logic [mpq_pkg::ADDR_W-1:0]                      paddr_i,
  input wire logic [mpq_pkg::DATA_W-1:0]                      prdata_o,
  input wire logic                                            pready_o,
  input wire logic                                            pslverr_o,
  // readouts and configuration
  input wire mpq_pkg::mpq_dsp_t                               dsp_i,
  input wire logic [mpq_pkg::PHASES-1:0][mpq_pkg::PWR_W-1:0]  meas_vrms_i,
  input wire mpq_pkg::mpq_cfg_t                               cfg_o,
  input wire logic [mpq_pkg::PHASES-1:0][mpq_pkg::PWR_W-1:0]  vrms_used_o
);
  // ------------
  // helpers
  // ------------
  logic [17:0]                                    idx;
  logic                                           is_rsvd;
  logic                                           is_ro;
  logic [31:0]                                    pwr_a_se;
  logic [mpq_pkg::PHASES-1:0][mpq_pkg::PWR_W-1:0] vrms_exp;
  assign idx      = paddr_i[19:2];
  assign is_rsvd  = idx inside {[18'h0e521:18'h0e52e], [18'h0e604:18'h0e606],
                                [18'h0e609:18'h0e60b]};
  assign is_ro    = idx inside {[18'h0e519:18'h0e51b], 18'h0e51f, [18'h0e600:18'h0e603],
                                18'h0e607, 18'h0e608};
  assign pwr_a_se = {{8{dsp_i.apparent_power[0][23]}}, dsp_i.apparent_power[0]};
  always_comb
  begin
    for (int p = 0; p < mpq_pkg::PHASES; p++)
      vrms_exp[p] = cfg_o.nominal_voltage_enable[p] ? cfg_o.nominal_voltage : meas_vrms_i[p];
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_first_access;
    psel_i && penable_i && !pready_o;
  endsequence
  // ------------
  // properties
  // ------------
  a_one_wait_state: assert property (s_first_access |=> pready_o ##1 !pready_o)
    else $error("ready timing wrong");
  a_ready_cause: assert property (pready_o |-> $past(psel_i) && $past(penable_i))
    else $error("ready without access");
  a_idle_data_zero: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data not zero when idle");
  a_rsvd_error: assert property (s_first_access ##0 is_rsvd |=> pslverr_o)
    else $error("reserved not refused");
  a_err_data_zero: assert property (pready_o && pslverr_o |-> prdata_o == 32'h0)
    else $error("error data nonzero");
  a_ro_write_quiet: assert property (s_first_access ##0 (pwrite_i && is_ro)
    |=> !pslverr_o ##1 $stable(cfg_o)) else $error("read-only write had effect");
  a_pwr_sign_ext: assert property (s_first_access
    ##0 (!pwrite_i && idx == 18'h0e519) |=> prdata_o == $past(pwr_a_se))
    else $error("apparent power not sign extended");
  a_delay_zero_pad: assert property (s_first_access
    ##0 (!pwrite_i && idx == 18'h0e601) |=> prdata_o == {16'h0, $past(dsp_i.phase_delay[0])})
    else $error("delay readout wrong");
  a_vrms_substitute: assert property ($past(nrst_i) |-> vrms_used_o == $past(vrms_exp))
    else $error("voltage substitution wrong");
endmodule

bind mpq_regs mpq_regs_chk i_mpq_regs_chk (.sys_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .prdata_o, .pready_o, .pslverr_o, .dsp_i, .meas_vrms_i, .cfg_o, .vrms_used_o);

// [test/meter_power_quality_regs_bench.sv]
// testbench: apb stimulus and readback checks for the power quality register bank
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module meter_power_quality_regs_bench;
  logic               clk = 1'b0;
  logic               nrst = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [19:0]        paddr = 20'h0;
  logic [31:0]        pwdata = 32'h0;
  logic [3:0]         pstrb = 4'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  mpq_pkg::mpq_dsp_t  dsp = '0;
  logic [2:0][23:0]   meas = '0;
  mpq_pkg::mpq_cfg_t  cfg;
  logic [2:0][23:0]   vrms;
  int                 n_mismatch = 0;
  int                 compares = 0;
  logic [31:0]        seed = 32'hb874;
  logic [17:0]        ridx [6] = '{18'h0e51f, 18'h0e520, 18'h0e60c,
                                   18'h0e60d, 18'h0e60e, 18'h0e60f};
  logic [31:0]        rval [6] = '{32'h33666787, 32'h0, 32'hffff,
                                   32'hffff, 32'h01ff, 32'h0};
  logic [17:0]        sidx [6] = '{18'h0e521, 18'h0e52e, 18'h0e604,
                                   18'h0e606, 18'h0e609, 18'h0e60b};
  logic [17:0]        widx [5] = '{18'h0e520, 18'h0e60c, 18'h0e60d, 18'h0e60e, 18'h0e60f};
  int                 wlen [5] = '{24, 16, 16, 16, 16};
  logic [31:0]        shad [5] = '{32'h0, 32'hffff, 32'hffff, 32'h01ff, 32'h0};

  initial forever #5 clk = ~clk;

  mpq_regs i_mpq_regs (.sys_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .dsp_i(dsp), .meas_vrms_i(meas), .cfg_o(cfg),
    .vrms_used_o(vrms));

  // ------------
  // helpers
  // ------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // byte merge under strobes, then bits above the register width read back as zero
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s, input int w);
    logic [31:0] r;
    for (int b = 0; b < 4; b++)
      r[8*b+:8] = s[b] ? n[8*b+:8] : o[8*b+:8];
    return r & ~(32'hffffffff << w);
  endfunction

  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // entered just after a rising edge; idle edge at the end avoids double drives
  task automatic apb(input logic wr, input logic [17:0] idx, input logic [31:0] wd,
                     input logic [3:0] st, output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // read in the edge's own time step: these are the values that edge samples
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_mismatch++;
      $display("ERROR t=%0t no ready", $time);
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // ------------
  // scenarios
  // ------------
  initial
  begin
    logic [31:0] rd, v, ex;
    logic [3:0] s;
    logic er;
    logic [223:0] r;
    logic [15:0] h [6];
    mpq_pkg::mpq_dsp_t t;
    mpq_pkg::mpq_cfg_t snap;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, ridx[i], 32'h0, 4'h0, rd, er);
      `CHK(rd, rval[i])
    end
    $display("test reset values done");
    for (int k = 0; k < 2; k++)
    begin
      r = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      t = r[$bits(t)-1:0];
      t.checksum_upd = 1'b0;
      if (k == 0)
        t.apparent_power[0] = 24'h800000;
      dsp <= t;
      @(posedge clk);
      for (int p = 0; p < 3; p++)
      begin
        apb(1'b0, 18'(18'h0e519 + p), 32'h0, 4'h0, rd, er);
        `CHK(rd, 32'(signed'(t.apparent_power[p])))
      end
      h = '{t.phase_peak_status, t.phase_delay[0], t.phase_delay[1], t.phase_delay[2],
            t.line_period, t.phase_noload_status};
      foreach (h[j])
      begin
        apb(1'b0, (j < 4) ? 18'(18'h0e600 + j) : 18'(18'h0e603 + j), 32'h0, 4'h0, rd, er);
        `CHK(rd, {16'h0, h[j]})
      end
      apb(1'b1, 18'h0e51f, rnd(), 4'hf, rd, er);
      `CHK(er, 1'b0)
      apb(1'b0, 18'h0e51f, 32'h0, 4'h0, rd, er);
      `CHK(rd, 32'h33666787)
    end
    $display("test readouts done");
    for (int i = 0; i < 5; i++)
      for (int k = 0; k < 3; k++)
      begin
        v = (k == 0) ? 32'hffffffff : rnd();
        s = (k == 0) ? 4'hf : 4'(rnd());
        ex = merge(shad[i], v, s, wlen[i]);
        apb(1'b1, widx[i], v, s, rd, er);
        apb(1'b0, widx[i], 32'h0, 4'h0, rd, er);
        `CHK(rd, ex)
        shad[i] = ex;
      end
    $display("test writable registers done");
    snap = cfg;
    foreach (sidx[i])
    begin
      // reads only: software must never write the reserved ranges
      apb(1'b0, sidx[i], 32'h0, 4'h0, rd, er);
      `CHK(er, 1'b1)
      apb(1'b0, sidx[i], 32'h0, 4'h0, rd, er);
      `CHK(rd, 32'h0)
    end
    `CHK(cfg, snap)
    $display("test reserved ranges done");
    t.checksum = rnd();
    t.checksum_upd = 1'b1;
    dsp <= t;
    @(posedge clk);
    t.checksum_upd = 1'b0;
    dsp <= t;
    apb(1'b0, 18'h0e51f, 32'h0, 4'h0, rd, er);
    `CHK(rd, t.checksum)
    $display("test checksum load done");
    for (int k = 0; k < 3; k++)
    begin
      meas <= {24'(rnd()), 24'(rnd()), 24'(rnd())};
      v = {8'h0, 24'(rnd())};
      s = (k == 0) ? 4'h5 : 4'(rnd());
      apb(1'b1, 18'h0e520, v, 4'hf, rd, er);
      apb(1'b1, 18'h0e530, {29'h0, s[2:0]}, 4'hf, rd, er);
      apb(1'b0, 18'h0e530, 32'h0, 4'h0, rd, er);
      `CHK(rd, {29'h0, s[2:0]})
      repeat (2) @(posedge clk);
      @(negedge clk);
      for (int p = 0; p < 3; p++)
        `CHK(vrms[p], s[p] ? v[23:0] : meas[p])
      @(posedge clk);
    end
    $display("test nominal substitution done");
    wrap_up();
  end
endmodule
